// file: logic/frp_consts.svh
`ifndef FRP_CONSTS_SVH
`define FRP_CONSTS_SVH
// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define FRP_ACR_ADDR 32'h40022000
`define FRP_ACR_LAT_MSB 2
`define FRP_ACR_LAT_LSB 0
`define FRP_ACR_HALF_BIT 3
`define FRP_ACR_PFEN_BIT 4
`define FRP_ACR_PFST_BIT 5
`define FRP_ACR_RST_LAT 3'h0
`define FRP_ACR_RST_HALF 1'h0
`define FRP_ACR_RST_PFEN 1'h1
`define FRP_LAT_MAX 3'h2
`define FRP_RESP_OKAY 2'h0
`define FRP_RESP_SLVERR 2'h2
`define FRP_HTRANS_ACT_BIT 1
// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define FRP_PAGES 32
`define FRP_PAGE_BYTES 2048
`define FRP_WORD_BYTES 8
`define FRP_ARR_WORDS (`FRP_PAGES * `FRP_PAGE_BYTES / `FRP_WORD_BYTES)
`define FRP_WORD_W 64
`define FRP_LINE_W 13
`define FRP_TAG_W 12
`define FRP_OFS_W 16
`define FRP_HALF_SEL_BIT 2
`define FRP_LINE_LSB 3
`define FRP_NUM_BLOCKS 2
`endif

// file: logic/frp_pkg.sv
`include "frp_consts.svh"
package frp_pkg;
  // ----------------------------------------------------------------
  // arbiter encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRP_IDLE = 2'h0,
    FRP_ACCESS = 2'h1,
    FRP_CAPTURE = 2'h2
  } frp_arb_t;
  typedef enum logic [1:0] {
    FRP_OWN_DATA = 2'h0,
    FRP_OWN_IDEM = 2'h1,
    FRP_OWN_PREF = 2'h2
  } frp_own_t;
  // ----------------------------------------------------------------
  // whole state of the read interface
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] lat;
    logic half;
    logic pfen;
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_strb0;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic i_pend;
    logic [`FRP_OFS_W-1:0] i_addr;
    logic [31:0] i_rdata;
    logic d_pend;
    logic [`FRP_OFS_W-1:0] d_addr;
    logic [31:0] d_rdata;
    logic [`FRP_NUM_BLOCKS-1:0] blk_valid;
    logic [`FRP_NUM_BLOCKS-1:0][`FRP_TAG_W-1:0] blk_tag;
    logic [`FRP_NUM_BLOCKS-1:0][`FRP_WORD_W-1:0] blk_data;
    logic [`FRP_LINE_W-1:0] pf_line;
    frp_arb_t arb;
    frp_own_t own;
    logic [2:0] cnt;
    logic [2:0] lat_run;
    logic [`FRP_LINE_W-1:0] line;
  } frp_state_t;
  typedef struct packed {
    logic [`FRP_WORD_W-1:0] rd_data;
  } frp_mem_state_t;
endpackage

// file: logic/frp_arr_if.sv
`timescale 1ns/1ps
`include "frp_consts.svh"
// array read and preload signals between controller and array
interface frp_arr_if;
  logic rd_en;
  logic [`FRP_LINE_W-1:0] rd_addr;
  logic [`FRP_WORD_W-1:0] rd_data;
  logic ld_we;
  logic [`FRP_LINE_W-1:0] ld_addr;
  logic [`FRP_WORD_W-1:0] ld_data;
  modport ctrl (output rd_en, output rd_addr, output ld_we, output ld_addr, output ld_data,
    input rd_data);
  modport mem (input rd_en, input rd_addr, input ld_we, input ld_addr, input ld_data,
    output rd_data);
endinterface

// file: logic/frp_array_mem.sv
`timescale 1ns/1ps
`include "frp_consts.svh"
module frp_array_mem #(
  parameter int WORDS = `FRP_ARR_WORDS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  frp_arr_if.mem arr
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the controller addresses with a fixed line width
  if (WORDS != (1 << `FRP_LINE_W)) begin : g_chk
    $error("frp_array_mem: WORDS must match the line address width");
  end
  logic [`FRP_WORD_W-1:0] cells [WORDS];
  frp_pkg::frp_mem_state_t st_reg;
  frp_pkg::frp_mem_state_t st_next;

  // cells carry no reset, only the output register does
  always_ff @(posedge i_clk) begin
    if (arr.ld_we) begin
      cells[arr.ld_addr] <= arr.ld_data;
    end
  end

  // read data only moves while the read controls are active
  always_comb begin
    st_next = st_reg;
    if (arr.rd_en) begin
      st_next.rd_data = cells[arr.rd_addr];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign arr.rd_data = st_reg.rd_data;
endmodule // frp_array_mem

// file: logic/frp_flash_read.sv
// Functional notes
// - two prefetch blocks, each one 64-bit word
// - blocks direct-mapped, tagged to aligned lines
// - one array read fills a whole block
// - prefetch read only while a block is free
// - only instruction fetches use the buffer
// - data bus wins the array arbitration
// - array read controls and bus slaves here, cells in frp_array_mem
// - data path shares the access timing logic
// - prefetch enabled straight out of reset
// - half-cycle bit gives single cycle accesses
// - three-bit latency holds controls zero..two waits
// - latency resets to zero, single cycle access
// - array is 32 pages of 2K, 64-bit words
// - array readable as plain memory
`timescale 1ns/1ps
`include "frp_consts.svh"
module frp_flash_read (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic [31:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [31:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic I_IB_HSEL,
  input wire logic [31:0] I_IB_HADDR,
  input wire logic [1:0] I_IB_HTRANS,
  input wire logic I_IB_HWRITE,
  input wire logic I_IB_HREADY,
  output logic O_IB_HREADYOUT,
  output logic [31:0] O_IB_HRDATA,
  output logic O_IB_HRESP,
  input wire logic I_DB_HSEL,
  input wire logic [31:0] I_DB_HADDR,
  input wire logic [1:0] I_DB_HTRANS,
  input wire logic I_DB_HWRITE,
  input wire logic I_DB_HREADY,
  output logic O_DB_HREADYOUT,
  output logic [31:0] O_DB_HRDATA,
  output logic O_DB_HRESP,
  input wire logic I_LD_WE,
  input wire logic [`FRP_LINE_W-1:0] I_LD_ADDR,
  input wire logic [`FRP_WORD_W-1:0] I_LD_DATA
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [`FRP_LINE_W-1:0] LINE_ONE = `FRP_LINE_W'(1);
  if (`FRP_NUM_BLOCKS != 2) begin : g_chk
    $error("frp_flash_read: the block index logic serves exactly two blocks");
  end

  function automatic logic is_ctl(input logic [31:0] a);
    is_ctl = (a[31:2] == `FRP_ACR_ADDR >> 2);
  endfunction

  function automatic logic [31:0] word_sel(input logic [`FRP_WORD_W-1:0] d, input logic hi);
    word_sel = hi ? d[`FRP_WORD_W-1:32] : d[31:0];
  endfunction

  function automatic logic [`FRP_LINE_W-1:0] line_of(input logic [`FRP_OFS_W-1:0] a);
    line_of = a[`FRP_OFS_W-1:`FRP_LINE_LSB];
  endfunction

  frp_pkg::frp_state_t r;
  frp_pkg::frp_state_t n;
  frp_arr_if arr_bus ();

  logic [`FRP_LINE_W-1:0] i_line;
  logic i_idx;
  logic i_hit;
  logic dem_req;
  logic pf_req;
  logic [2:0] lat_eff;
  logic [31:0] ctl_word;

  // ----------------------------------------------------------------
  // decode of the pending fetch against the buffer
  // ----------------------------------------------------------------
  assign i_line = line_of(r.i_addr);
  assign i_idx = i_line[0];
  assign i_hit = r.pfen && r.blk_valid[i_idx] && (r.blk_tag[i_idx] == i_line[`FRP_LINE_W-1:1]);
  // with the buffer off every fetch is a direct read
  assign dem_req = r.i_pend && !i_hit;
  assign pf_req = r.pfen && !r.blk_valid[r.pf_line[0]];
  // half-cycle mode collapses the access to one cycle whatever the field says
  assign lat_eff = r.half ? 3'h0 : ((r.lat > `FRP_LAT_MAX) ? `FRP_LAT_MAX : r.lat);
  assign ctl_word = {26'h0, |r.blk_valid, r.pfen, r.half, r.lat};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // register bus write: address and data may arrive in either order
    if (I_AXI_AWVALID && O_AXI_AWREADY) begin
      n.aw_have = 1'b1;
      n.aw_addr = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && O_AXI_WREADY) begin
      n.w_have = 1'b1;
      n.w_byte = I_AXI_WDATA[7:0];
      n.w_strb0 = I_AXI_WSTRB[0];
    end
    if (r.aw_have && r.w_have) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.b_valid = 1'b1;
      if (is_ctl(r.aw_addr)) begin
        n.b_resp = `FRP_RESP_OKAY;
        if (r.w_strb0) begin
          n.lat = r.w_byte[`FRP_ACR_LAT_MSB:`FRP_ACR_LAT_LSB];
          n.half = r.w_byte[`FRP_ACR_HALF_BIT];
          n.pfen = r.w_byte[`FRP_ACR_PFEN_BIT];
        end
      end else begin
        n.b_resp = `FRP_RESP_SLVERR;
      end
    end
    if (r.b_valid && I_AXI_BREADY) begin
      n.b_valid = 1'b0;
    end
    // register bus read, answered one cycle after the address is taken
    if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      n.r_valid = 1'b1;
      if (is_ctl(I_AXI_ARADDR)) begin
        n.r_data = ctl_word;
        n.r_resp = `FRP_RESP_OKAY;
      end else begin
        n.r_data = 32'h0;
        n.r_resp = `FRP_RESP_SLVERR;
      end
    end
    if (r.r_valid && I_AXI_RREADY) begin
      n.r_valid = 1'b0;
    end
    // a disabled buffer holds nothing, so re-enabling starts clean
    if (!r.pfen) begin
      n.blk_valid = '0;
    end
    // address phases; writes are taken with no wait and ignored
    if (I_IB_HSEL && I_IB_HTRANS[`FRP_HTRANS_ACT_BIT] && I_IB_HREADY && !I_IB_HWRITE) begin
      n.i_pend = 1'b1;
      n.i_addr = I_IB_HADDR[`FRP_OFS_W-1:0];
    end
    if (I_DB_HSEL && I_DB_HTRANS[`FRP_HTRANS_ACT_BIT] && I_DB_HREADY && !I_DB_HWRITE) begin
      n.d_pend = 1'b1;
      n.d_addr = I_DB_HADDR[`FRP_OFS_W-1:0];
    end
    // fetch hit: answer from the buffer; the upper half frees the block
    if (r.i_pend && i_hit) begin
      n.i_rdata = word_sel(r.blk_data[i_idx], r.i_addr[`FRP_HALF_SEL_BIT]);
      n.i_pend = 1'b0;
      if (r.i_addr[`FRP_HALF_SEL_BIT]) begin
        n.blk_valid[i_idx] = 1'b0;
      end
    end
    // flash access arbiter and shared access timer
    case (r.arb)
      frp_pkg::FRP_IDLE: begin
        n.cnt = 3'h0;
        n.lat_run = lat_eff;
        if (r.d_pend) begin
          n.arb = frp_pkg::FRP_ACCESS;
          n.own = frp_pkg::FRP_OWN_DATA;
          n.line = line_of(r.d_addr);
        end else if (dem_req) begin
          n.arb = frp_pkg::FRP_ACCESS;
          n.own = frp_pkg::FRP_OWN_IDEM;
          n.line = i_line;
        end else if (pf_req) begin
          n.arb = frp_pkg::FRP_ACCESS;
          n.own = frp_pkg::FRP_OWN_PREF;
          n.line = r.pf_line;
        end
      end
      frp_pkg::FRP_ACCESS: begin
        // read controls stay up for lat_run extra cycles
        if (r.cnt == r.lat_run) begin
          n.arb = frp_pkg::FRP_CAPTURE;
        end else begin
          n.cnt = r.cnt + 3'h1;
        end
      end
      frp_pkg::FRP_CAPTURE: begin
        n.arb = frp_pkg::FRP_IDLE;
        case (r.own)
          frp_pkg::FRP_OWN_DATA: begin
            // literal reads bypass the buffer entirely
            n.d_rdata = word_sel(arr_bus.rd_data, r.d_addr[`FRP_HALF_SEL_BIT]);
            n.d_pend = 1'b0;
          end
          frp_pkg::FRP_OWN_IDEM: begin
            n.i_rdata = word_sel(arr_bus.rd_data, r.i_addr[`FRP_HALF_SEL_BIT]);
            n.i_pend = 1'b0;
            if (r.pfen) begin
              // a jump restarts the stream: the other block is stale
              n.blk_valid = '0;
              n.blk_valid[r.line[0]] = !r.i_addr[`FRP_HALF_SEL_BIT];
              n.blk_tag[r.line[0]] = r.line[`FRP_LINE_W-1:1];
              n.blk_data[r.line[0]] = arr_bus.rd_data;
              n.pf_line = r.line + LINE_ONE;
            end
          end
          default: begin
            // a prefetch landing after a disable is dropped
            if (r.pfen) begin
              n.blk_valid[r.line[0]] = 1'b1;
              n.blk_tag[r.line[0]] = r.line[`FRP_LINE_W-1:1];
              n.blk_data[r.line[0]] = arr_bus.rd_data;
              n.pf_line = r.line + LINE_ONE;
            end
          end
        endcase
      end
      default: begin
        n.arb = frp_pkg::FRP_IDLE;
      end
    endcase
  end

  // state register; prefetch comes up enabled
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r <= '0;
      r.lat <= `FRP_ACR_RST_LAT;
      r.half <= `FRP_ACR_RST_HALF;
      r.pfen <= `FRP_ACR_RST_PFEN;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // array and outputs
  // ----------------------------------------------------------------
  assign arr_bus.rd_en = (r.arb == frp_pkg::FRP_ACCESS);
  assign arr_bus.rd_addr = r.line;
  assign arr_bus.ld_we = I_LD_WE;
  assign arr_bus.ld_addr = I_LD_ADDR;
  assign arr_bus.ld_data = I_LD_DATA;

  frp_array_mem #(
    .WORDS(`FRP_ARR_WORDS)
  ) u_mem (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .arr(arr_bus)
  );

  // a pending response blocks new addresses, one write in flight
  assign O_AXI_AWREADY = !r.aw_have && !r.b_valid;
  assign O_AXI_WREADY = !r.w_have && !r.b_valid;
  assign O_AXI_BVALID = r.b_valid;
  assign O_AXI_BRESP = r.b_resp;
  assign O_AXI_ARREADY = !r.r_valid;
  assign O_AXI_RVALID = r.r_valid;
  assign O_AXI_RDATA = r.r_data;
  assign O_AXI_RRESP = r.r_resp;
  assign O_IB_HREADYOUT = !r.i_pend;
  assign O_IB_HRDATA = r.i_rdata;
  assign O_IB_HRESP = 1'b0;
  assign O_DB_HREADYOUT = !r.d_pend;
  assign O_DB_HRDATA = r.d_rdata;
  assign O_DB_HRESP = 1'b0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic seen_wr_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      seen_wr_reg <= 1'b0;
    end else if (r.aw_have && r.w_have) begin
      seen_wr_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  a_pf_on_reset: assert property (!seen_wr_reg |-> r.pfen)
    else $error("prefetch not enabled before any register write");
  a_lat_single: assert property ($rose(arr_bus.rd_en) && r.lat_run == 3'h0
    |=> !arr_bus.rd_en && r.arb == frp_pkg::FRP_CAPTURE)
    else $error("zero latency access not single cycle");
  a_lat_two_wait: assert property ($rose(arr_bus.rd_en) && r.lat_run == 3'h2
    |-> arr_bus.rd_en [*3] ##1 !arr_bus.rd_en)
    else $error("two wait state access wrong length");
  a_half_cycle: assert property (r.arb == frp_pkg::FRP_IDLE && r.half
    && (r.d_pend || dem_req || pf_req) |=> r.lat_run == 3'h0)
    else $error("half-cycle access not single cycle");
  a_data_first: assert property (r.arb == frp_pkg::FRP_IDLE && r.d_pend
    |=> r.arb == frp_pkg::FRP_ACCESS && r.own == frp_pkg::FRP_OWN_DATA)
    else $error("data bus not granted first");
  a_pf_only_free: assert property (r.arb == frp_pkg::FRP_IDLE && !r.d_pend && !dem_req
    ##1 r.arb == frp_pkg::FRP_ACCESS |-> $past(pf_req))
    else $error("prefetch issued with no free block");
  a_pf_issue: assert property (r.arb == frp_pkg::FRP_IDLE && !r.d_pend && !dem_req && pf_req
    |=> r.own == frp_pkg::FRP_OWN_PREF && r.line == $past(r.pf_line))
    else $error("free block not prefetched");
  a_fill_whole: assert property (r.arb == frp_pkg::FRP_CAPTURE
    && r.own == frp_pkg::FRP_OWN_PREF && r.pfen
    |=> r.blk_data[$past(r.line[0])] == $past(arr_bus.rd_data))
    else $error("prefetch block not filled from one read");
  a_dbus_bypass: assert property (r.arb == frp_pkg::FRP_CAPTURE
    && r.own == frp_pkg::FRP_OWN_DATA && r.pfen && !(r.i_pend && i_hit)
    |=> $stable(r.blk_data) && $stable(r.blk_tag))
    else $error("data bus read touched the buffer");
  a_miss_read: assert property (r.arb == frp_pkg::FRP_IDLE && !r.d_pend && dem_req
    |=> r.own == frp_pkg::FRP_OWN_IDEM && r.line == $past(i_line)
    ##[1:4] r.arb == frp_pkg::FRP_CAPTURE ##1 !r.i_pend)
    else $error("fetch miss not served by direct read");
  a_unmapped: assert property (I_AXI_ARVALID && O_AXI_ARREADY && !is_ctl(I_AXI_ARADDR)
    |=> O_AXI_RVALID && O_AXI_RRESP == `FRP_RESP_SLVERR)
    else $error("unmapped read not answered with slave error");

  c_pf_fill: cover property (r.arb == frp_pkg::FRP_CAPTURE && r.own == frp_pkg::FRP_OWN_PREF);
  c_ib_hit: cover property (r.i_pend && i_hit);
  c_db_over_ib: cover property (r.arb == frp_pkg::FRP_IDLE && r.d_pend && dem_req);
  c_lat_two: cover property ($rose(arr_bus.rd_en) && r.lat_run == 3'h2);
endmodule // frp_flash_read

// file: test/frp_ahb_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// processor side bus master, one read at a time
// ----------------------------------------------------------------
module frp_ahb_master (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic o_tog,
  output logic [31:0] o_data,
  output logic [7:0] o_cyc,
  output logic o_hang
);
  // idle bus at time zero
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_tog = 1'b0;
    o_data = 32'h0;
    o_cyc = 8'h0;
    o_hang = 1'b0;
  end
  // sampled just before the edge, since inputs only move after it
  task automatic read(input logic [31:0] a);
    logic rdy;
    logic [31:0] d;
    int n;
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= 2'h2;
    rdy = 1'b0;
    n = 0;
    while (!rdy && n < 100) begin
      @(negedge i_clk);
      rdy = (i_hready === 1'b1);
      n++;
      @(posedge i_clk);
    end
    o_hsel <= 1'b0;
    o_htrans <= 2'h0;
    o_haddr <= ~a; // released address never repeats the old one
    rdy = 1'b0;
    n = 0;
    while (!rdy && n < 100) begin
      @(negedge i_clk);
      rdy = (i_hready === 1'b1);
      d = i_hrdata;
      n++;
      @(posedge i_clk);
    end
    o_hang <= (n >= 100);
    o_cyc <= n[7:0];
    o_data <= d;
    o_tog <= ~o_tog;
  endtask
endmodule // frp_ahb_master

// file: test/tb.sv
`timescale 1ns/1ps
`include "frp_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ld_we = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'h48;
  logic [3:0] wstrb = 4'h0;
  logic [12:0] ld_addr = 13'h0;
  logic [63:0] ld_data = 64'h0, mem [16];
  logic [39:0] q_i[$], q_d[$], e;
  logic [33:0] q_r[$];
  logic [1:0] q_b[$];
  logic tog_i = 1'b0, tog_d = 1'b0, ib_sel, db_sel, ib_wr, db_wr, ib_rdy, db_rdy;
  logic [1:0] ib_tr, db_tr;
  logic [31:0] ib_ad, db_ad, ib_rd, db_rd;
  logic ib_resp, db_resp;
  logic [7:0] v [5] = '{8'h10, 8'h11, 8'h12, 8'h17, 8'h1A};
  logic [7:0] c [5] = '{8'h4, 8'h5, 8'h6, 8'h6, 8'h4};
  int miscompares = 0, comparisons = 0;
  wire [31:0] RDATA;
  wire [1:0] RRESP, BRESP;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID;
  initial begin
    forever #5 clk = ~clk;
  end
  frp_flash_read dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_AXI_AWADDR(awaddr),
    .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(AWREADY), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(WREADY), .O_AXI_BRESP(BRESP), .O_AXI_BVALID(BVALID),
    .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(ARREADY), .O_AXI_RDATA(RDATA), .O_AXI_RRESP(RRESP), .O_AXI_RVALID(RVALID),
    .I_AXI_RREADY(rready), .I_IB_HSEL(ib_sel), .I_IB_HADDR(ib_ad), .I_IB_HTRANS(ib_tr),
    .I_IB_HWRITE(ib_wr), .I_IB_HREADY(ib_rdy), .O_IB_HREADYOUT(ib_rdy), .O_IB_HRDATA(ib_rd),
    .O_IB_HRESP(ib_resp), .I_DB_HSEL(db_sel), .I_DB_HADDR(db_ad), .I_DB_HTRANS(db_tr),
    .I_DB_HWRITE(db_wr), .I_DB_HREADY(db_rdy), .O_DB_HREADYOUT(db_rdy), .O_DB_HRDATA(db_rd),
    .O_DB_HRESP(db_resp), .I_LD_WE(ld_we), .I_LD_ADDR(ld_addr), .I_LD_DATA(ld_data));
  frp_ahb_master m_ib (.i_clk(clk), .i_hready(ib_rdy), .i_hrdata(ib_rd), .o_hsel(ib_sel),
    .o_haddr(ib_ad), .o_htrans(ib_tr), .o_hwrite(ib_wr), .o_tog(), .o_data(), .o_cyc(), .o_hang());
  frp_ahb_master m_db (.i_clk(clk), .i_hready(db_rdy), .i_hrdata(db_rd), .o_hsel(db_sel),
    .o_haddr(db_ad), .o_htrans(db_tr), .o_hwrite(db_wr), .o_tog(), .o_data(), .o_cyc(), .o_hang());
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ex(input logic [31:0] a);
    return a[2] ? mem[a[6:3]][63:32] : mem[a[6:3]][31:0];
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    end_of_test();
  endtask
  // register write: address and data offered together, each dropped once taken
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    logic ta, tw, b;
    int n;
    q_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 100) begin
      @(negedge clk);
      ta = awvalid && AWREADY === 1'b1;
      tw = wvalid && WREADY === 1'b1;
      b = BVALID === 1'b1;
      n++;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (ta) awaddr <= ~a;
      if (tw) wvalid <= 1'b0;
      if (tw) wdata <= ~d;
    end
    bready <= 1'b0;
    if (!b) hang();
  endtask
  task automatic axr(input logic [31:0] a, input logic [33:0] x);
    logic ta, rv;
    int n;
    q_r.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    n = 0;
    while (!rv && n < 100) begin
      @(negedge clk);
      ta = arvalid && ARREADY === 1'b1;
      rv = RVALID === 1'b1;
      n++;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (ta) araddr <= ~a;
    end
    rready <= 1'b0;
    if (!rv) hang();
  endtask
  task automatic ib(input logic [31:0] a, input logic [7:0] c);
    q_i.push_back({c, ex(a)});
    m_ib.read(a);
  endtask
  task automatic db(input logic [31:0] a, input logic [7:0] c);
    q_d.push_back({c, ex(a)});
    m_db.read(a);
  endtask
  // ----------------------------------------------------------------
  // result watcher: oldest note against each answer
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (m_ib.o_hang || m_db.o_hang) hang();
    if (RVALID === 1'b1 && rready) begin
      e = q_r.pop_front();
      `CHK("rdata", e[33:0], {RRESP, RDATA})
    end
    if (BVALID === 1'b1 && bready) begin
      e = q_b.pop_front();
      `CHK("bresp", e[1:0], BRESP)
    end
    if (m_ib.o_tog !== tog_i) begin
      tog_i = m_ib.o_tog;
      e = q_i.pop_front();
      `CHK("ib data", e[31:0], m_ib.o_data)
      `CHK("ib resp", 1'b0, ib_resp)
      if (e[39:32] != 8'h0) `CHK("ib cycles", e[39:32], m_ib.o_cyc)
    end
    if (m_db.o_tog !== tog_d) begin
      tog_d = m_db.o_tog;
      e = q_d.pop_front();
      `CHK("db data", e[31:0], m_db.o_data)
      `CHK("db resp", 1'b0, db_resp)
      `CHK("db cycles", e[39:32], m_db.o_cyc)
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // preload while reset holds: the buffer starts filling right after release
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      seed = lfsr(seed);
      mem[i] = {seed, ~seed ^ 32'(i)};
      ld_we <= 1'b1;
      ld_addr <= 13'(i);
      ld_data <= mem[i];
    end
    rstn <= 1'b1;
    @(posedge clk);
    ld_we <= 1'b0;
    // first prefetch not landed yet, so bit 5 still clear
    axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 32'h10});
    axw(`FRP_ACR_ADDR, 32'hFFFFFF12, 4'hF, `FRP_RESP_OKAY);
    axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 32'h32});
    axw(`FRP_ACR_ADDR, 32'h10, 4'h0, `FRP_RESP_OKAY);
    axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 32'h32});
    axw(`FRP_ACR_ADDR + 32'h4, 32'h10, 4'hF, `FRP_RESP_SLVERR);
    axr(`FRP_ACR_ADDR + 32'h4, {`FRP_RESP_SLVERR, 32'h0});
    // each latency setting against the data bus timing; the clock is never divided
    for (int k = 0; k < 5; k++) begin
      axw(`FRP_ACR_ADDR, {24'h0, v[k]}, 4'h1, `FRP_RESP_OKAY);
      axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 24'h0, v[k] | 8'h20});
      db(32'h08000000 + 32'(k * 12), c[k]);
    end
    // flush, then re-enable: the refill of line 2 delays the first miss by one cycle
    axw(`FRP_ACR_ADDR, 32'h0, 4'h1, `FRP_RESP_OKAY);
    axw(`FRP_ACR_ADDR, 32'h10, 4'h1, `FRP_RESP_OKAY);
    ib(32'h08000000, 8'h5);
    ib(32'h08000004, 8'h2);
    axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 32'h30});
    for (int k = 2; k < 8; k++) ib(32'h00000000 + 32'(k * 4), 8'h0);
    // the prefetch of line 5 still holds the array when this read arrives
    db(32'h08000010, 8'h5);
    axw(`FRP_ACR_ADDR, 32'h0, 4'h1, `FRP_RESP_OKAY);
    axr(`FRP_ACR_ADDR, {`FRP_RESP_OKAY, 32'h0});
    ib(32'h08000024, 8'h4);
    // both buses at once: data bus goes first, fetch waits a whole access
    fork
      ib(32'h08000030, 8'h7);
      db(32'h08000038, 8'h4);
    join
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule // tb
